// [include/ctp_pkg.sv]
// Constants, register map and carrier types for the compare trigger / PWM unit.
// Assumes an Avalon-MM master with 32-bit data; each 8-bit register sits in
// the low byte of its own word.
//
// How it works
// - Mode 1010 sets match flag, pin untouched
// - Mode 1011 emits internal trigger pulse
// - Trigger same cycle as 16-bit match
// - Counter A cleared on next timer edge
// - Trigger starts conversion only if enabled
// - Trigger reset never sets overflow flag
// - Match removed before edge skips reset
// - PWM mode drives pulse width, 10 bits
// - Zero unit control forces output inactive
// - Period is (limit+1)*4*Tosc*prescale
// - Prescaler divides by 1, 4, 16
// - Limit match clears counter, sets, reloads
// - Postscaler has no effect on period
// - Duty = compare low byte : two bits
// - Duty copied to buffer after match
// - High time is duty*Tosc*prescale
// - Clear pin when buffer equals fine count
// - New duty starts at next period
// - Resolution is log2(4*(limit+1)) bits
// - Duty beyond period leaves pin unchanged
// - Sleep freezes counters and pin level
// - 110x active high, 111x active low
// - Mode 0000 turns off, resets state
package ctp_pkg;

  // Register indexes; byte address is index times four
  localparam logic [8:0] IDX_IRQ_CTRL = 9'h00b;
  localparam logic [8:0] IDX_IRQ_FLAGS = 9'h00c;
  localparam logic [8:0] IDX_CNT_A_LO = 9'h00e;
  localparam logic [8:0] IDX_CNT_A_HI = 9'h00f;
  localparam logic [8:0] IDX_CNT_A_CTRL = 9'h010;
  localparam logic [8:0] IDX_PER_CNT = 9'h011;
  localparam logic [8:0] IDX_PER_CTRL = 9'h012;
  localparam logic [8:0] IDX_CMP_LO = 9'h013;
  localparam logic [8:0] IDX_CMP_HI = 9'h014;
  localparam logic [8:0] IDX_UNIT_CTRL = 9'h015;
  localparam logic [8:0] IDX_PORT_DIR = 9'h087;
  localparam logic [8:0] IDX_IRQ_EN = 9'h08c;
  localparam logic [8:0] IDX_PER_LIM = 9'h092;
  localparam logic [8:0] IDX_CMP_SYNC = 9'h11b;

  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PORT_DIR = 8'h3f;
  localparam logic [7:0] RST_PER_LIM = 8'hff;
  localparam logic [7:0] RST_CMP_SYNC = 8'h02;

  // Field positions
  localparam int unsigned FLD_MATCH = 5;
  localparam int unsigned FLD_PER_FLAG = 1;
  localparam int unsigned FLD_OVF = 0;
  localparam int unsigned FLD_WAVE_DIR = 5;
  localparam int unsigned FLD_CNT_A_ON = 0;
  localparam int unsigned FLD_PER_ON = 2;
  localparam int unsigned FLD_PS_LSB = 0;
  localparam int unsigned FLD_DUTY_LSB = 4;
  localparam int unsigned FLD_POLARITY = 1;
  localparam logic [7:0] UNIT_WR_MASK = 8'h3f;
  localparam logic [7:0] PER_CTRL_WR_MASK = 8'h7f;

  // Mode select encodings
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_SWI = 4'ha;
  localparam logic [3:0] MODE_TRIG = 4'hb;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;

  // Timing: one counter step is four prescaled phases
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [3:0] PS_LIM_1 = 4'h0;
  localparam logic [3:0] PS_LIM_4 = 4'h3;
  localparam logic [3:0] PS_LIM_16 = 4'hf;

  typedef struct packed {
    logic read;
    logic write;
    logic [10:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } ctp_avs_req_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } ctp_bus_st_t;

  typedef struct packed {
    logic [3:0] ps_cnt;
    logic [1:0] phase;
  } ctp_tb_state_t;

  typedef struct packed {
    ctp_bus_st_t bus;
    logic [31:0] rdata;
    logic [7:0] irq_ctl;
    logic [7:0] flags;
    logic [7:0] cnt_a_lo;
    logic [7:0] cnt_a_hi;
    logic [7:0] cnt_a_ctl;
    logic [7:0] per_cnt;
    logic [7:0] per_ctl;
    logic [7:0] cmp_lo;
    logic [7:0] cmp_hi;
    logic [7:0] unit;
    logic [7:0] port_dir;
    logic [7:0] irq_en;
    logic [7:0] per_lim;
    logic [7:0] cmp_sync;
    logic [9:0] duty;
    logic pwm;
    logic wave;
  } ctp_state_t;

endpackage

// [src/ctp_timebase.sv]
// Prescaler and quarter-phase counter feeding the period counter.
// Assumes run is low in sleep and clear is high while the counter is off.
`timescale 1ns/1ps
`default_nettype none
module ctp_timebase
  import ctp_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_run,
  input wire logic i_clear,
  input wire logic [1:0] i_ps_sel,
  output logic [1:0] o_phase,
  output logic o_step
);

  ctp_tb_state_t s_q;
  ctp_tb_state_t s_d;
  logic [3:0] lim;
  logic tick;

  always_comb begin
    case (i_ps_sel)
      2'b00: lim = PS_LIM_1;
      2'b01: lim = PS_LIM_4;
      default: lim = PS_LIM_16;
    endcase
  end

  assign tick = i_run && (s_q.ps_cnt == lim);
  // Counter advances once per four prescaled phases
  assign o_step = tick && (s_q.phase == PHASE_LAST);
  // Next phase, so the core can clear the pin on the edge that reaches the duty
  assign o_phase = s_d.phase;

  always_comb begin
    s_d = s_q;
    if (i_clear) begin
      s_d.ps_cnt = 4'h0;
      s_d.phase = 2'h0;
    end else if (i_run) begin
      if (tick) begin
        s_d.ps_cnt = 4'h0;
        s_d.phase = s_q.phase + 2'h1;
      end else begin
        s_d.ps_cnt = s_q.ps_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule
`default_nettype wire

// [src/ctp_core.sv]
// Compare trigger, software-interrupt compare and double-buffered PWM unit.
// Assumes an Avalon-MM master, synchronous pins and a sleep level from
// the power controller; the external wire is resolved from o_wave_oe.
`timescale 1ns/1ps
`default_nettype none
module ctp_core
  import ctp_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire ctp_avs_req_t i_avs,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_sleep,
  input wire logic i_adc_enable,
  output logic o_special_trigger,
  output logic o_adc_start,
  output logic o_match_irq,
  output logic o_wave_out,
  output logic o_wave_oe
);

  localparam ctp_state_t STATE_RST = '{
    bus: BUS_IDLE,
    rdata: 32'h0,
    irq_ctl: RST_ZERO,
    flags: RST_ZERO,
    cnt_a_lo: RST_ZERO,
    cnt_a_hi: RST_ZERO,
    cnt_a_ctl: RST_ZERO,
    per_cnt: RST_ZERO,
    per_ctl: RST_ZERO,
    cmp_lo: RST_ZERO,
    cmp_hi: RST_ZERO,
    unit: RST_ZERO,
    port_dir: RST_PORT_DIR,
    irq_en: RST_ZERO,
    per_lim: RST_PER_LIM,
    cmp_sync: RST_CMP_SYNC,
    duty: 10'h0,
    pwm: 1'b0,
    wave: 1'b0
  };

  ctp_state_t s_q;
  ctp_state_t s_d;

  logic [8:0] idx;
  logic req;
  logic wr_fire;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  logic [3:0] mode;
  logic pwm_mode;
  logic [15:0] cnt_a;
  logic cmp_match;
  logic trig;
  logic cnt_a_run;
  logic per_run;
  logic [1:0] phase;
  logic step;
  logic wrap;
  logic [9:0] fine;
  logic [9:0] duty_new;
  logic [7:0] per_nxt;

  assign idx = i_avs.address[10:2];
  assign req = i_avs.read || i_avs.write;
  // Write lands on the edge where waitrequest is seen low
  assign wr_fire = i_avs.write && (s_q.bus == BUS_ACK) && i_avs.byteenable[0];
  assign wbyte = i_avs.writedata[7:0];
  assign o_avs_waitrequest = req && (s_q.bus != BUS_ACK);
  assign o_avs_readdata = s_q.rdata;

  assign mode = s_q.unit[3:0];
  assign pwm_mode = (mode[3:2] == MODE_PWM_TOP);
  assign cnt_a = {s_q.cnt_a_hi, s_q.cnt_a_lo};
  assign cmp_match = (cnt_a == {s_q.cmp_hi, s_q.cmp_lo});
  // Combinational so the strobe sits in the match cycle itself
  assign trig = (mode == MODE_TRIG) && cmp_match;
  assign o_special_trigger = trig;
  assign o_adc_start = trig && i_adc_enable;
  assign cnt_a_run = s_q.cnt_a_ctl[FLD_CNT_A_ON] && !i_sleep;
  assign per_run = s_q.per_ctl[FLD_PER_ON] && !i_sleep;
  assign o_match_irq = s_q.flags[FLD_MATCH] && s_q.irq_en[FLD_MATCH];
  assign o_wave_out = s_q.wave;
  // Driven only while software has cleared the direction bit
  assign o_wave_oe = !s_q.port_dir[FLD_WAVE_DIR];

  ctp_timebase u_timebase (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_run(per_run),
    .i_clear(!s_q.per_ctl[FLD_PER_ON]),
    .i_ps_sel(s_q.per_ctl[FLD_PS_LSB +: 2]),
    .o_phase(phase),
    .o_step(step)
  );

  // Postscaler bits are stored only and never gate the wrap
  assign wrap = step && (s_q.per_cnt == s_q.per_lim);
  // Coming count, so the pin drops on the edge that reaches the duty, not one late
  assign per_nxt = !step ? s_q.per_cnt : (wrap ? 8'h00 : s_q.per_cnt + 8'h01);
  assign fine = {per_nxt, phase};
  assign duty_new = {s_q.cmp_lo, s_q.unit[FLD_DUTY_LSB +: 2]};

  always_comb begin
    case (idx)
      IDX_IRQ_CTRL: rd_byte = s_q.irq_ctl;
      IDX_IRQ_FLAGS: rd_byte = s_q.flags;
      IDX_CNT_A_LO: rd_byte = s_q.cnt_a_lo;
      IDX_CNT_A_HI: rd_byte = s_q.cnt_a_hi;
      IDX_CNT_A_CTRL: rd_byte = s_q.cnt_a_ctl;
      IDX_PER_CNT: rd_byte = s_q.per_cnt;
      IDX_PER_CTRL: rd_byte = s_q.per_ctl;
      IDX_CMP_LO: rd_byte = s_q.cmp_lo;
      IDX_CMP_HI: rd_byte = s_q.cmp_hi;
      IDX_UNIT_CTRL: rd_byte = s_q.unit;
      IDX_PORT_DIR: rd_byte = s_q.port_dir;
      IDX_IRQ_EN: rd_byte = s_q.irq_en;
      IDX_PER_LIM: rd_byte = s_q.per_lim;
      IDX_CMP_SYNC: rd_byte = s_q.cmp_sync;
      default: rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    logic [16:0] cnt_a_inc;
    logic set_match;
    logic set_ovf;
    logic set_per;
    cnt_a_inc = {1'b0, cnt_a} + 17'h00001;
    set_match = 1'b0;
    set_ovf = 1'b0;
    set_per = 1'b0;
    s_d = s_q;

    // Bus handshake: one wait cycle, data registered on entry to ACK
    case (s_q.bus)
      BUS_IDLE: begin
        if (req) begin
          s_d.bus = BUS_ACK;
          s_d.rdata = {24'h000000, rd_byte};
        end
      end
      BUS_ACK: begin
        s_d.bus = BUS_IDLE;
      end
      default: begin
        s_d.bus = BUS_IDLE;
      end
    endcase

    // Counter A; match re-checked at the edge, so a moved compare skips it
    if (cnt_a_run) begin
      if (trig) begin
        {s_d.cnt_a_hi, s_d.cnt_a_lo} = 16'h0000;
      end else begin
        {s_d.cnt_a_hi, s_d.cnt_a_lo} = cnt_a_inc[15:0];
        set_ovf = cnt_a_inc[16];
      end
    end
    if ((mode == MODE_SWI || mode == MODE_TRIG) && cmp_match) begin
      set_match = 1'b1;
    end

    // Period counter
    if (step) begin
      if (wrap) begin
        s_d.per_cnt = 8'h00;
        set_per = 1'b1;
      end else begin
        s_d.per_cnt = s_q.per_cnt + 8'h01;
      end
    end

    // PWM latch and duty buffer
    if (mode == MODE_OFF) begin
      s_d.duty = 10'h000;
      s_d.pwm = 1'b0;
    end else if (!pwm_mode) begin
      s_d.pwm = 1'b0;
    end else if (wrap) begin
      s_d.duty = duty_new;
      s_d.cmp_hi = s_q.cmp_lo;
      s_d.pwm = (duty_new != 10'h000);
    end else if (!i_sleep && fine == s_q.duty) begin
      // Never matches when duty exceeds the period, so the level holds
      s_d.pwm = 1'b0;
    end

    // Register writes; software beats hardware on data registers
    if (wr_fire) begin
      case (idx)
        IDX_IRQ_CTRL: s_d.irq_ctl = wbyte;
        IDX_IRQ_FLAGS: s_d.flags = wbyte;
        IDX_CNT_A_LO: s_d.cnt_a_lo = wbyte;
        IDX_CNT_A_HI: s_d.cnt_a_hi = wbyte;
        IDX_CNT_A_CTRL: s_d.cnt_a_ctl = wbyte;
        IDX_PER_CNT: s_d.per_cnt = wbyte;
        IDX_PER_CTRL: s_d.per_ctl = wbyte & PER_CTRL_WR_MASK;
        IDX_CMP_LO: s_d.cmp_lo = wbyte;
        IDX_CMP_HI: begin
          // Read-only while the PWM owns it as the duty buffer
          if (!pwm_mode) begin
            s_d.cmp_hi = wbyte;
          end
        end
        IDX_UNIT_CTRL: begin
          s_d.unit = wbyte & UNIT_WR_MASK;
          if ((wbyte & UNIT_WR_MASK) == RST_ZERO) begin
            s_d.pwm = 1'b0;
            s_d.duty = 10'h000;
          end
        end
        IDX_PORT_DIR: s_d.port_dir = wbyte;
        IDX_IRQ_EN: s_d.irq_en = wbyte;
        IDX_PER_LIM: s_d.per_lim = wbyte;
        IDX_CMP_SYNC: s_d.cmp_sync = wbyte;
        default: begin
        end
      endcase
    end

    // Hardware set wins over a clear in the same cycle
    if (set_match) begin
      s_d.flags[FLD_MATCH] = 1'b1;
    end
    if (set_ovf) begin
      s_d.flags[FLD_OVF] = 1'b1;
    end
    if (set_per) begin
      s_d.flags[FLD_PER_FLAG] = 1'b1;
    end

    // Pin level: off forces inactive, compare modes leave it alone
    if (s_d.unit[3:0] == MODE_OFF) begin
      s_d.wave = 1'b0;
    end else if (s_d.unit[3:2] == MODE_PWM_TOP) begin
      s_d.wave = s_d.pwm ^ s_d.unit[FLD_POLARITY];
    end else begin
      s_d.wave = s_q.wave;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  localparam int BUS_MAX_WAIT = 1;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_trig_run;
    trig && cnt_a_run && !wr_fire;
  endsequence

  sequence s_wrap_quiet;
    wrap && pwm_mode && !wr_fire;
  endsequence

  property p_swi_flag;
    (mode == MODE_SWI) && cmp_match |=> s_q.flags[FLD_MATCH];
  endproperty
  a_swi_flag: assert property (p_swi_flag) else $error("match flag not set");

  property p_swi_pin;
    (mode == MODE_SWI) && !wr_fire |=> $stable(o_wave_out);
  endproperty
  a_swi_pin: assert property (p_swi_pin) else $error("pin moved in interrupt mode");

  property p_trig_now;
    (mode == MODE_TRIG) && cmp_match |-> o_special_trigger;
  endproperty
  a_trig_now: assert property (p_trig_now) else $error("trigger late");

  property p_trig_reset;
    s_trig_run |=> (cnt_a == 16'h0000);
  endproperty
  a_trig_reset: assert property (p_trig_reset) else $error("counter not cleared");

  property p_adc_gate;
    o_adc_start |-> o_special_trigger && i_adc_enable;
  endproperty
  a_adc_gate: assert property (p_adc_gate) else $error("conversion without enable");

  property p_no_ovf;
    s_trig_run |=> !s_q.flags[FLD_OVF] || $past(s_q.flags[FLD_OVF]);
  endproperty
  a_no_ovf: assert property (p_no_ovf) else $error("overflow flag on trigger reset");

  property p_unit_zero;
    wr_fire && (idx == IDX_UNIT_CTRL) && ((wbyte & UNIT_WR_MASK) == RST_ZERO)
      |=> !s_q.pwm && !o_wave_out;
  endproperty
  a_unit_zero: assert property (p_unit_zero) else $error("output not forced inactive");

  property p_wrap;
    s_wrap_quiet |=> (s_q.per_cnt == 8'h00) && (s_q.duty == $past(duty_new))
      && (s_q.pwm == ($past(duty_new) != 10'h000));
  endproperty
  a_wrap: assert property (p_wrap) else $error("period wrap wrong");

  property p_duty_clear;
    pwm_mode && !wrap && !i_sleep && (fine == s_q.duty) |=> !s_q.pwm;
  endproperty
  a_duty_clear: assert property (p_duty_clear) else $error("pin not cleared at duty");

  property p_sleep;
    i_sleep && !wr_fire |=> $stable(s_q.per_cnt) && $stable(cnt_a) && $stable(o_wave_out);
  endproperty
  a_sleep: assert property (p_sleep) else $error("state moved in sleep");

  property p_polarity;
    pwm_mode |-> (o_wave_out == (s_q.pwm ^ s_q.unit[FLD_POLARITY]));
  endproperty
  a_polarity: assert property (p_polarity) else $error("wrong output polarity");

  property p_zero_duty;
    pwm_mode && (s_q.duty == 10'h000) |-> !s_q.pwm;
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("zero duty went active");

  property p_bus_answer;
    req |-> ##[0:BUS_MAX_WAIT] !o_avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

endmodule
`default_nettype wire

// [tb/ctp_tb.sv]
// Self-checking bench for the compare trigger / PWM unit.
// Assumes ctp_core as the unit under test, with the Avalon-MM slave giving one wait cycle.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ctp_pkg::*;
  logic i_mclk;
  logic i_rst_n;
  ctp_avs_req_t avs;
  logic i_sleep;
  logic i_adc_enable;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic o_special_trigger;
  logic o_adc_start;
  logic o_match_irq;
  logic o_wave_out;
  logic o_wave_oe;
  int fails;
  int samples_checked;
  int cyc;

  ctp_core uut (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_avs(avs),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .i_sleep(i_sleep),
    .i_adc_enable(i_adc_enable),
    .o_special_trigger(o_special_trigger),
    .o_adc_start(o_adc_start),
    .o_match_irq(o_match_irq),
    .o_wave_out(o_wave_out),
    .o_wave_oe(o_wave_oe)
  );

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Generous ceiling; the whole run needs about a thousand cycles
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus cycle; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [8:0] idx, input logic [7:0] d,
                     output logic [31:0] r);
    int n;
    @(posedge i_mclk);
    avs <= '{read: ~wr, write: wr, address: {idx, 2'b00}, byteenable: 4'h1,
             writedata: {24'h000000, d}};
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    r = o_avs_readdata;
    if (n >= 50) begin
      fails++;
      close_out();
    end
    avs <= '0;
  endtask

  task automatic wr(input logic [8:0] idx, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask

  task automatic rd_chk(input logic [8:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    bus(1'b0, idx, 8'h00, r);
    chk(r, {24'h000000, exp});
  endtask

  task automatic t_reset();
    chk(o_wave_oe, 1'b0);
    rd_chk(IDX_UNIT_CTRL, 8'h00);
    rd_chk(IDX_PORT_DIR, 8'h3f);
    rd_chk(IDX_PER_LIM, 8'hff);
    rd_chk(IDX_CMP_SYNC, 8'h02);
    rd_chk(IDX_IRQ_FLAGS, 8'h00);
    wr(9'h1ff, 8'h5a);
    rd_chk(9'h1ff, 8'h00);
    wr(IDX_UNIT_CTRL, 8'hc0);
    rd_chk(IDX_UNIT_CTRL, 8'h00);
    wr(IDX_PORT_DIR, 8'h1f);
    @(posedge i_mclk);
    chk(o_wave_oe, 1'b1);
    $display("test reset done");
  endtask

  task automatic t_swi();
    logic w;
    w = o_wave_out;
    wr(IDX_CMP_LO, 8'h10);
    wr(IDX_CMP_HI, 8'h00);
    wr(IDX_UNIT_CTRL, {4'h0, MODE_SWI});
    wr(IDX_CNT_A_CTRL, 8'h01);
    repeat (30) @(posedge i_mclk);
    rd_chk(IDX_IRQ_FLAGS, 8'h20);
    chk(o_match_irq, 1'b0);
    wr(IDX_IRQ_EN, 8'h20);
    @(posedge i_mclk);
    chk(o_match_irq, 1'b1);
    chk(o_wave_out, w);
    $display("test software interrupt done");
  endtask

  task automatic t_trig();
    int n;
    wr(IDX_UNIT_CTRL, {4'h0, MODE_TRIG});
    // Counter A is already past the compare value; restart it below the match
    wr(IDX_CNT_A_LO, 8'h00);
    for (int i = 0; i < 2; i++) begin
      i_adc_enable <= (i == 0);
      n = 0;
      do begin
        @(posedge i_mclk);
        n++;
      end while (o_special_trigger !== 1'b1 && n < 200);
      chk(o_special_trigger, 1'b1);
      chk(o_adc_start, (i == 0));
      @(posedge i_mclk);
      chk(o_special_trigger, 1'b0);
    end
    rd_chk(IDX_CNT_A_HI, 8'h00);
    rd_chk(IDX_IRQ_FLAGS, 8'h20);
    $display("test special trigger done");
  endtask

  task automatic pwm_case(input logic [3:0] m, input logic [7:0] lim, input logic [1:0] ps,
                          input logic [9:0] duty);
    int psf;
    int per;
    int hi;
    int cnt;
    psf = (ps == 2'h0) ? 1 : (ps == 2'h1) ? 4 : 16;
    per = (int'(lim) + 1) * 4 * psf;
    hi = (int'(duty) * psf > per) ? per : int'(duty) * psf;
    if (m[1]) hi = per - hi;
    wr(IDX_PER_LIM, lim);
    wr(IDX_PER_CTRL, {6'h01, ps});
    wr(IDX_CMP_LO, duty[9:2]);
    wr(IDX_UNIT_CTRL, {2'b00, duty[1:0], m});
    // Two settling periods so the buffered duty is in force
    repeat (2 * per + 8) @(posedge i_mclk);
    cnt = 0;
    repeat (2 * per) begin
      @(posedge i_mclk);
      cnt += (o_wave_out === 1'b1);
    end
    chk(cnt, 2 * hi);
    rd_chk(IDX_CMP_HI, duty[9:2]);
    $display("test pwm mode %h limit %h done", m, lim);
  endtask

  task automatic t_sleep();
    logic w;
    logic [31:0] a;
    logic [31:0] b;
    i_sleep <= 1'b1;
    @(posedge i_mclk);
    @(posedge i_mclk);
    w = o_wave_out;
    bus(1'b0, IDX_PER_CNT, 8'h00, a);
    repeat (20) begin
      @(posedge i_mclk);
      chk(o_wave_out, w);
    end
    bus(1'b0, IDX_PER_CNT, 8'h00, b);
    chk(b, a);
    i_sleep <= 1'b0;
    $display("test sleep done");
  endtask

  task automatic t_off();
    wr(IDX_UNIT_CTRL, 8'h00);
    repeat (3) @(posedge i_mclk);
    chk(o_wave_out, 1'b0);
    $display("test unit off done");
  endtask

  initial begin
    fails = 0;
    samples_checked = 0;
    cyc = 0;
    i_rst_n = 1'b0;
    avs = '0;
    i_sleep = 1'b0;
    i_adc_enable = 1'b0;
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    t_reset();
    t_swi();
    t_trig();
    // Limits only grow so the period counter never runs past a new limit
    pwm_case(4'hc, 8'h00, 2'h0, 10'h002);
    pwm_case(4'hc, 8'h00, 2'h1, 10'h008);
    pwm_case(4'he, 8'h01, 2'h0, 10'h005);
    t_sleep();
    pwm_case(4'hd, 8'h01, 2'h2, 10'h001);
    pwm_case(4'hc, 8'h01, 2'h0, 10'h000);
    pwm_case(4'hf, 8'h01, 2'h1, 10'h000);
    t_off();
    close_out();
  end
endmodule
`default_nettype wire
